/* File: design/spfs_defs.vh */
// Register map, field positions and timing constants of the serial port
`ifndef SPFS_DEFS_VH
`define SPFS_DEFS_VH
`define SPFS_ADDR_DATA 4'h0
`define SPFS_ADDR_CONTROL 4'h4
`define SPFS_ADDR_STATUS 4'h8
`define SPFS_ADDR_POWER 4'hc
`define SPFS_CR_IRQ_EN 7
`define SPFS_CR_OUT_EN 6
`define SPFS_CR_HALVE_DIS 5
`define SPFS_CR_MASTER 4
`define SPFS_CR_IDLE_LVL 3
`define SPFS_CR_CAPTURE 2
`define SPFS_SR_DONE 7
`define SPFS_SR_WRITE_COLLISION_FLAG 6
`define SPFS_SR_MODE_FAULT_FLAG 4
`define SPFS_PW_WAIT 0
`define SPFS_PW_HALT 1
`define SPFS_PW_CCMASK 2
`define SPFS_CR_RESET 8'h00
`define SPFS_SR_RESET 8'h00
`define SPFS_BITS_PER_BYTE 4'h8
`define SPFS_HALF_DIV4 7'h02
`define SPFS_HALF_DIV8 7'h04
`define SPFS_HALF_DIV16 7'h08
`define SPFS_HALF_DIV32 7'h10
`define SPFS_HALF_DIV64 7'h20
`define SPFS_HALF_DIV128 7'h40
`endif

/* File: design/spfs_serial_port.v */
// Serial port control, status, fault handling and shift engine with AXI4-Lite registers
// Contract
// - Data write during a transfer sets the write collision flag, status bit 6.
// - Write collision flag never raises the interrupt.
// - Mid-transfer: status read then data read clears collision; data write does not.
// - After done: status read then data write clears collision unless a transfer started.
// - Slave select low while master sets the mode fault flag.
// - Mode fault clears the output enable bit, releasing the pins.
// - Mode fault clears master select, making the port a slave.
// - Mode fault clears after status access while set, then a control write.
// - While fault set, output enable and master set are refused, except clearing write.
// - No mode fault in slave mode; an existing flag stays readable.
// - Without a done clear, the first received byte is kept, later ones dropped.
// - In wait state the port runs and its interrupt events wake the processor.
// - In halt the port freezes; its events do not wake from halt.
// - One interrupt: enable bit 7 and a flag set and processor mask clear.
// - Control bit 6 routes pins to the port; cleared by reset and mode fault.
// - Master divider by bits 5,1,0: 100/4 000/8 001/16 110/32 010/64 011/128.
// - Rate bits unused as slave; slave shifts on the received clock.
// - Control bit 4 selects master, driving the clock and swapping data pins.
// - Control bit 3 sets the idle clock level in both modes.
// - Control bit 2 picks first or second clock transition for capture.
// - Done flag, status bit 7, set at completion; status read then data access clears.
// - While the done flag is set, data writes are discarded.
// - Data write loads the 8-bit shifter, sent MSB first; master write starts it.
// - A colliding write leaves the running transfer and the shifter untouched.
// - On completion the received byte goes to a buffer read from the data register.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "spfs_defs.vh"
module spfs_serial_port (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sclk_in,
    output reg sclk_out,
    output reg sclk_oe,
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe,
    input wire miso_in,
    output reg miso_out,
    output reg miso_oe,
    input wire slave_select_n,
    output reg serial_irq,
    output reg wake_request
);
    reg [7:0] ctrl_reg;
    reg done_reg, write_collision_flag_reg, mode_fault_flag_reg;
    reg done_armed_reg, write_collision_flag_armed_reg, mode_fault_flag_armed_reg, write_collision_flag_after_done_reg;
    reg started_since_arm_reg;
    reg wait_reg, halt_reg, ccmask_reg;
    reg [7:0] shift_reg, rxbuf_reg;
    reg rxbit_reg;
    reg [3:0] bitcnt_reg;
    reg busy_reg, sck_int_reg, phase_hi_reg;
    reg [6:0] divcnt_reg;
    reg [2:0] ss_sync_reg, sck_sync_reg;
    reg ss_reg, sck_reg;
    reg aw_got_reg, w_got_reg;
    reg [3:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire master = ctrl_reg[`SPFS_CR_MASTER];
    wire out_en = ctrl_reg[`SPFS_CR_OUT_EN];
    wire idle_clock_level = ctrl_reg[`SPFS_CR_IDLE_LVL];
    wire capture_edge_select = ctrl_reg[`SPFS_CR_CAPTURE];
    wire run = ~halt_reg;

    // Three-stage synchronisers; change accepted once stages 2 and 3 agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            ss_sync_reg <= 3'h7;
            sck_sync_reg <= 3'h0;
            ss_reg <= 1'b1;
            sck_reg <= 1'b0;
        end else begin
            ss_sync_reg <= {ss_sync_reg[1:0], slave_select_n};
            sck_sync_reg <= {sck_sync_reg[1:0], sclk_in};
            if (ss_sync_reg[1] == ss_sync_reg[2])
                ss_reg <= ss_sync_reg[2];
            if (sck_sync_reg[1] == sck_sync_reg[2])
                sck_reg <= sck_sync_reg[2];
        end
    end
    reg sck_prev_reg;
    always @(posedge aclk) begin
        if (!aresetn)
            sck_prev_reg <= 1'b0;
        else
            sck_prev_reg <= sck_reg;
    end
    wire sck_edge = sck_reg ^ sck_prev_reg;
    // Leading edge leaves idle level, trailing edge returns to it
    wire slave_lead = sck_edge & (sck_reg != idle_clock_level);
    wire slave_trail = sck_edge & (sck_reg == idle_clock_level);

    // Half-period of serial clock, in CPU clocks
    reg [6:0] half_div;
    always @* begin
        case ({ctrl_reg[`SPFS_CR_HALVE_DIS], ctrl_reg[1:0]})
            3'b100: half_div = `SPFS_HALF_DIV4;
            3'b000: half_div = `SPFS_HALF_DIV8;
            3'b001: half_div = `SPFS_HALF_DIV16;
            3'b110: half_div = `SPFS_HALF_DIV32;
            3'b010: half_div = `SPFS_HALF_DIV64;
            3'b011: half_div = `SPFS_HALF_DIV128;
            // Unlisted rate codes fall back to the divide-by-eight rate
            default: half_div = `SPFS_HALF_DIV8;
        endcase
    end

    // AXI write and read decode
    wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire rd_fire = s_axi_arvalid & s_axi_arready;
    wire wr_data = wr_fire & (aw_addr_reg == `SPFS_ADDR_DATA) & w_strb_reg[0];
    wire wr_ctrl = wr_fire & (aw_addr_reg == `SPFS_ADDR_CONTROL) & w_strb_reg[0];
    wire wr_stat = wr_fire & (aw_addr_reg == `SPFS_ADDR_STATUS);
    wire wr_pwr = wr_fire & (aw_addr_reg == `SPFS_ADDR_POWER) & w_strb_reg[0];
    wire rd_data = rd_fire & (s_axi_araddr == `SPFS_ADDR_DATA);
    wire rd_stat = rd_fire & (s_axi_araddr == `SPFS_ADDR_STATUS);
    // Status write is a bus access too, counted as arming for fault clear
    wire stat_acc = rd_stat | wr_stat;

    // Master engine: tick each half period while busy
    wire tick = busy_reg & master & (divcnt_reg == half_div - 7'h01);
    wire m_lead = tick & ~phase_hi_reg;
    wire m_trail = tick & phase_hi_reg;
    wire lead = master ? m_lead : (slave_lead & ~ss_reg);
    wire trail = master ? m_trail : (slave_trail & ~ss_reg);
    // Capture on first edge when phase 0, second when phase 1
    wire cap = capture_edge_select ? trail : lead;
    wire shf = capture_edge_select ? lead : trail;
    wire last_cap = cap & (bitcnt_reg == `SPFS_BITS_PER_BYTE - 4'h1);
    // Slave with phase 0 is committed as soon as selected
    wire in_xfer = busy_reg | (~master & out_en & ~ss_reg & ~capture_edge_select);
    wire collide = wr_data & in_xfer & ~done_reg;
    wire load_ok = wr_data & ~in_xfer & ~done_reg & out_en;
    wire fault = master & out_en & ~ss_reg;
    wire sin = master ? miso_in : mosi_in;

    always @(posedge aclk) begin
        if (!aresetn) begin
            shift_reg <= 8'h00;
            rxbuf_reg <= 8'h00;
            rxbit_reg <= 1'b0;
            bitcnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            divcnt_reg <= 7'h00;
            phase_hi_reg <= 1'b0;
            sck_int_reg <= 1'b0;
        end else if (run) begin
            if (tick) begin
                divcnt_reg <= 7'h00;
                phase_hi_reg <= ~phase_hi_reg;
                sck_int_reg <= ~sck_int_reg;
            end else if (busy_reg & master)
                divcnt_reg <= divcnt_reg + 7'h01;
            if (load_ok) begin
                shift_reg <= w_data_reg[7:0];
                bitcnt_reg <= 4'h0;
                busy_reg <= master;
                divcnt_reg <= 7'h00;
                phase_hi_reg <= 1'b0;
                sck_int_reg <= 1'b0;
            end else if (fault) begin
                busy_reg <= 1'b0;
            end else if (cap) begin
                rxbit_reg <= sin;
                bitcnt_reg <= bitcnt_reg + 4'h1;
                if (last_cap) begin
                    if (!done_reg)
                        rxbuf_reg <= {shift_reg[6:0], sin};
                    if (!capture_edge_select)
                        busy_reg <= 1'b1;
                end
            end else if (shf & (bitcnt_reg != 4'h0)) begin
                // Outgoing bit moves on the edge opposite capture, never with it
                shift_reg <= {shift_reg[6:0], rxbit_reg};
            end
            if (~master & slave_lead & ~ss_reg)
                busy_reg <= 1'b1;
            // Phase 1 master stops on its eighth capture, no extra clock pulse
            if (m_trail & ((bitcnt_reg == `SPFS_BITS_PER_BYTE) | last_cap))
                busy_reg <= 1'b0;
            if (~master & (ss_reg | (slave_trail & bitcnt_reg == `SPFS_BITS_PER_BYTE)))
                busy_reg <= 1'b0;
            if (~master & ss_reg)
                bitcnt_reg <= 4'h0;
        end
    end

    // Control register and flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `SPFS_CR_RESET;
            done_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            mode_fault_flag_reg <= 1'b0;
            done_armed_reg <= 1'b0;
            write_collision_flag_armed_reg <= 1'b0;
            mode_fault_flag_armed_reg <= 1'b0;
            write_collision_flag_after_done_reg <= 1'b0;
            started_since_arm_reg <= 1'b0;
            wait_reg <= 1'b0;
            halt_reg <= 1'b0;
            ccmask_reg <= 1'b0;
        end else begin
            if (wr_pwr) begin
                wait_reg <= w_data_reg[`SPFS_PW_WAIT];
                halt_reg <= w_data_reg[`SPFS_PW_HALT];
                ccmask_reg <= w_data_reg[`SPFS_PW_CCMASK];
            end
            if (run) begin
                if (wr_ctrl) begin
                    if (mode_fault_flag_reg & ~mode_fault_flag_armed_reg)
                        ctrl_reg <= {w_data_reg[7], ctrl_reg[6] & w_data_reg[6], w_data_reg[5],
                                     ctrl_reg[4] & w_data_reg[4], w_data_reg[3:0]};
                    else
                        ctrl_reg <= w_data_reg[7:0];
                end
                if (fault) begin
                    ctrl_reg[`SPFS_CR_OUT_EN] <= 1'b0;
                    ctrl_reg[`SPFS_CR_MASTER] <= 1'b0;
                    mode_fault_flag_reg <= 1'b1;
                    mode_fault_flag_armed_reg <= 1'b0;
                end else begin
                    if (stat_acc & mode_fault_flag_reg)
                        mode_fault_flag_armed_reg <= 1'b1;
                    if (wr_ctrl & mode_fault_flag_armed_reg) begin
                        mode_fault_flag_reg <= 1'b0;
                        mode_fault_flag_armed_reg <= 1'b0;
                    end
                end
                // Done flag: set wins over the clearing access
                if (rd_stat & done_reg)
                    done_armed_reg <= 1'b1;
                if (last_cap) begin
                    done_reg <= 1'b1;
                    done_armed_reg <= 1'b0;
                end else if ((rd_data | wr_data) & done_armed_reg) begin
                    done_reg <= 1'b0;
                    done_armed_reg <= 1'b0;
                end
                // Collision flag arming and clearing
                if (rd_stat & write_collision_flag_reg) begin
                    write_collision_flag_armed_reg <= 1'b1;
                    write_collision_flag_after_done_reg <= done_reg;
                    started_since_arm_reg <= 1'b0;
                end else if (load_ok | (~master & slave_lead & ~ss_reg))
                    started_since_arm_reg <= 1'b1;
                if (collide) begin
                    write_collision_flag_reg <= 1'b1;
                    write_collision_flag_armed_reg <= 1'b0;
                end else if (write_collision_flag_armed_reg & rd_data & ~write_collision_flag_after_done_reg) begin
                    write_collision_flag_reg <= 1'b0;
                    write_collision_flag_armed_reg <= 1'b0;
                end else if (write_collision_flag_armed_reg & wr_data & write_collision_flag_after_done_reg) begin
                    write_collision_flag_reg <= started_since_arm_reg;
                    write_collision_flag_armed_reg <= 1'b0;
                end
            end
        end
    end

    // Pins, interrupt and wake; collision flag is kept out of the request
    wire irq_src = ctrl_reg[`SPFS_CR_IRQ_EN] & (done_reg | mode_fault_flag_reg);
    always @(posedge aclk) begin
        if (!aresetn) begin
            serial_irq <= 1'b0;
            wake_request <= 1'b0;
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            serial_irq <= irq_src & ~ccmask_reg;
            wake_request <= irq_src & wait_reg & ~halt_reg;
            sclk_out <= sck_int_reg ^ idle_clock_level;
            sclk_oe <= out_en & master;
            mosi_out <= shift_reg[7];
            mosi_oe <= out_en & master;
            miso_out <= shift_reg[7];
            miso_oe <= out_en & ~master & ~ss_reg;
        end
    end

    // Status byte; unused bits read as zero
    reg [7:0] status_byte;
    always @* begin
        status_byte = `SPFS_SR_RESET;
        status_byte[`SPFS_SR_DONE] = done_reg;
        status_byte[`SPFS_SR_WRITE_COLLISION_FLAG] = write_collision_flag_reg;
        status_byte[`SPFS_SR_MODE_FAULT_FLAG] = mode_fault_flag_reg;
    end

    // AXI4-Lite slave; address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
            end
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                if (s_axi_araddr == `SPFS_ADDR_DATA)
                    s_axi_rdata <= {24'h0, rxbuf_reg};
                else if (s_axi_araddr == `SPFS_ADDR_CONTROL)
                    s_axi_rdata <= {24'h0, ctrl_reg};
                else if (s_axi_araddr == `SPFS_ADDR_STATUS)
                    s_axi_rdata <= {24'h0, status_byte};
                else if (s_axi_araddr == `SPFS_ADDR_POWER)
                    s_axi_rdata <= {29'h0, ccmask_reg, halt_reg, wait_reg};
                else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            end else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // spfs_serial_port
`default_nettype wire

/* File: tb/spfs_serial_port_assertions.sv */
// Pin and bus checks for the serial port
`timescale 1ns/100ps
`default_nettype none
module spfs_serial_port_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic slave_select_n,
    input wire logic serial_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence w_taken;
        s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_soon;
        ##[1:3] s_axi_bvalid;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WRITE_ANSWER: assert property (w_taken |-> b_soon)
        else $error("write response late");
    AST_READ_ANSWER: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read data late");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_FAULT_RELEASE: assert property (sclk_oe && !slave_select_n |-> ##[1:8] !sclk_oe)
        else $error("clock still driven after select low");
    AST_DIR_EXCL: assert property (!(mosi_oe && miso_oe))
        else $error("both data pins driven");
    AST_MASTER_DRIVES: assert property (sclk_oe |-> mosi_oe)
        else $error("master clock without data output");
    AST_HALF_MIN: assert property (sclk_oe && $changed(sclk_out) |=> $stable(sclk_out))
        else $error("clock half period under two cycles");
    AST_RESET_QUIET: assert property ($rose(aresetn) |-> !sclk_oe && !mosi_oe && !miso_oe && !serial_irq)
        else $error("pins active after reset");
endmodule // spfs_serial_port_assertions
bind spfs_serial_port spfs_serial_port_assertions spfs_serial_port_assertions_i (
    .aclk, .aresetn, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sclk_out, .sclk_oe, .mosi_oe,
    .miso_oe, .slave_select_n, .serial_irq
);
`default_nettype wire

/* File: tb/spfs_link_partner.sv */
// Far side slave on the serial link, idle low, capture on first edge
`timescale 1ns/100ps
`default_nettype none
module spfs_link_partner (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] tx_sh = 8'h00;
    logic [7:0] rx_sh = 8'h00;
    int cnt = 0;
    initial got = 8'h00;
    always @(negedge sel_n) begin
        tx_sh = reply;
        cnt = 0;
    end
    always @(posedge sclk) if (!sel_n) begin
        rx_sh = {rx_sh[6:0], mosi};
        cnt++;
        if (cnt == 8) begin
            got = rx_sh;
            cnt = 0;
        end
    end
    // Reload after each byte so every transfer answers the same
    always @(negedge sclk) if (!sel_n) tx_sh = (cnt == 0) ? reply : {tx_sh[6:0], ~tx_sh[7]};
    // Deselected line shows the inverse, never a stale bit
    always @* miso = sel_n ? ~tx_sh[7] : tx_sh[7];
endmodule // spfs_link_partner
`default_nettype wire

/* File: tb/tb_top.sv */
// Register-level bench for the serial port
`timescale 1ns/100ps
`default_nettype none
`include "spfs_defs.vh"
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_irq, wake_request;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, p_miso;
    logic slave_select_n = 1'b1;
    logic p_sel_n = 1'b1;
    logic [7:0] p_got;
    logic [7:0] rate_bits [6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
    int rate_div [6] = '{4, 8, 16, 32, 64, 128};
    int error_cnt = 0;
    int cmp_count = 0;
    int hi = 0;
    // Undriven lines are taken as pulled low
    wire logic sclk_w = sclk_oe ? sclk_out : 1'b0;
    wire logic mosi_w = mosi_oe ? mosi_out : 1'b0;
    wire logic miso_w = miso_oe ? miso_out : p_miso;
    always #50 aclk = ~aclk;
    always @(posedge aclk) if (sclk_w === 1'b1) hi++;
    spfs_serial_port spfs_serial_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sclk_in(sclk_w), .sclk_out, .sclk_oe, .mosi_in(mosi_w), .mosi_out,
        .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .slave_select_n, .serial_irq, .wake_request);
    spfs_link_partner spfs_link_partner_i (.sclk(sclk_w), .mosi(mosi_w), .sel_n(p_sel_n), .reply(8'h5a),
        .miso(p_miso), .got(p_got));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, 32'h0);
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = (a[1:0] != 2'b00) ? {30'h0, s_axi_rresp} : s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(rd, exp);
    endtask
    // Bounded wait on the shared request line
    task automatic wait_irq();
        int n;
        n = 0;
        while (serial_irq !== 1'b1 && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 3000) error_cnt++;
    endtask
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        p_sel_n <= 1'b0;
        bus_rd(`SPFS_ADDR_CONTROL, 32'h0);
        bus_rd(`SPFS_ADDR_STATUS, 32'h0);
        bus_rd(4'h2, 32'h2);
        for (int i = 0; i < 6; i++) begin
            bus_wr(`SPFS_ADDR_CONTROL, 8'hd0 | rate_bits[i]);
            hi = 0;
            bus_wr(`SPFS_ADDR_DATA, 8'hc3 ^ 8'(i));
            wait_irq();
            bus_rd(`SPFS_ADDR_STATUS, 32'h80);
            bus_rd(`SPFS_ADDR_DATA, 32'h5a);
            bus_rd(`SPFS_ADDR_STATUS, 32'h0);
            repeat (70) @(posedge aclk);
            chk(hi, 4 * rate_div[i]);
            chk({24'h0, p_got}, {24'h0, 8'hc3 ^ 8'(i)});
        end
        bus_wr(`SPFS_ADDR_CONTROL, 8'hd0);
        bus_wr(`SPFS_ADDR_DATA, 8'ha5);
        bus_wr(`SPFS_ADDR_DATA, 8'h3c);
        bus_rd(`SPFS_ADDR_STATUS, 32'h40);
        chk({31'h0, serial_irq}, 32'h0);
        bus_wr(`SPFS_ADDR_DATA, 8'h99);
        bus_rd(`SPFS_ADDR_STATUS, 32'h40);
        bus_rd(`SPFS_ADDR_DATA, 32'h5a);
        bus_rd(`SPFS_ADDR_STATUS, 32'h0);
        wait_irq();
        bus_wr(`SPFS_ADDR_DATA, 8'hee);
        bus_rd(`SPFS_ADDR_STATUS, 32'h80);
        bus_rd(`SPFS_ADDR_DATA, 32'h5a);
        repeat (100) @(posedge aclk);
        chk({24'h0, p_got}, 32'ha5);
        bus_wr(`SPFS_ADDR_DATA, 8'h81);
        bus_wr(`SPFS_ADDR_DATA, 8'h18);
        wait_irq();
        bus_rd(`SPFS_ADDR_STATUS, 32'hc0);
        bus_wr(`SPFS_ADDR_DATA, 8'h66);
        bus_rd(`SPFS_ADDR_STATUS, 32'h0);
        chk({24'h0, p_got}, 32'h81);
        slave_select_n <= 1'b0;
        repeat (8) @(posedge aclk);
        chk({31'h0, serial_irq}, 32'h1);
        bus_rd(`SPFS_ADDR_CONTROL, 32'h80);
        bus_wr(`SPFS_ADDR_POWER, 8'h01);
        repeat (3) @(posedge aclk);
        chk({31'h0, wake_request}, 32'h1);
        bus_wr(`SPFS_ADDR_POWER, 8'h03);
        repeat (3) @(posedge aclk);
        chk({31'h0, wake_request}, 32'h0);
        bus_wr(`SPFS_ADDR_POWER, 8'h04);
        repeat (3) @(posedge aclk);
        chk({31'h0, serial_irq}, 32'h0);
        bus_wr(`SPFS_ADDR_POWER, 8'h00);
        slave_select_n <= 1'b1;
        bus_wr(`SPFS_ADDR_CONTROL, 8'hd0);
        bus_rd(`SPFS_ADDR_CONTROL, 32'h80);
        bus_rd(`SPFS_ADDR_STATUS, 32'h10);
        bus_wr(`SPFS_ADDR_CONTROL, 8'h90);
        bus_rd(`SPFS_ADDR_STATUS, 32'h0);
        bus_rd(`SPFS_ADDR_CONTROL, 32'h90);
        bus_wr(`SPFS_ADDR_CONTROL, 8'h40);
        slave_select_n <= 1'b0;
        repeat (8) @(posedge aclk);
        chk({31'h0, miso_oe}, 32'h1);
        bus_rd(`SPFS_ADDR_STATUS, 32'h0);
        slave_select_n <= 1'b1;
        bus_wr(`SPFS_ADDR_CONTROL, 8'h58);
        repeat (4) @(posedge aclk);
        chk({31'h0, sclk_w}, 32'h1);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
